// ### rtl/bfn_pkg.sv
// constants and types of the feature negotiation register bank
// Notes on behaviour
// - flush always offered, surely with cache-config
// - cache-config without flush: cache mode writethrough (set at accept in modern mode only; legacy leaves it)
// - all padding bytes read as zero
// - zoned offered only if zoned, never legacy
// - zoned refused, HA/none: zoned fields zero
// - zoned refused, host-managed, modern mode: refuse features accepted
// - zoned negotiated: report the operating zone model
// - model codes: none 0, managed 1, aware 2
// - managed/aware: report the size of one zone
// - report open zone limit, zero means none
// - report active zone limit, zero means none
// - append limit never above segments times size
// - report write granularity for sequential zones
// - legacy: cache mode changes on cache writes, or at ready without cache-config
package bfn_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_FEAT_DEV = 8'h00;
    localparam logic [7:0] OFF_FEAT_DRV = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CACHE = 8'h0c;
    localparam logic [7:0] OFF_UNMAP = 8'h10;
    localparam logic [7:0] OFF_ZSECT = 8'h14;
    localparam logic [7:0] OFF_ZOPEN = 8'h18;
    localparam logic [7:0] OFF_ZACT = 8'h1c;
    localparam logic [7:0] OFF_ZAPP = 8'h20;
    localparam logic [7:0] OFF_ZGRAN = 8'h24;
    localparam logic [7:0] OFF_ZMODEL = 8'h28;
    localparam int FB_FLUSH = 0;
    localparam int FB_CACHECFG = 1;
    localparam int FB_DISCARD = 2;
    localparam int FB_ZONED = 3;
    localparam int ST_ACK = 0;
    localparam int ST_DRV = 1;
    localparam int ST_READY = 2;
    localparam int ST_FOK = 3;
    localparam int ST_FAIL = 7;
    localparam logic [7:0] MODEL_NONE = 8'h00;
    localparam logic [7:0] MODEL_HM = 8'h01;
    localparam logic [7:0] MODEL_HA = 8'h02;
    localparam logic CACHE_THROUGH = 1'b0;
    localparam logic CACHE_BACK = 1'b1;
    localparam logic [23:0] PAD_ZERO = 24'h000000;
    localparam logic [31:0] FEAT_RST = 32'h00000000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h00000000;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_NEGOT = 3'b001,
        PH_ACCEPT = 3'b010,
        PH_RUN = 3'b011,
        PH_FAIL = 3'b100
    } bfn_phase_e;
    typedef struct packed {
        logic [31:0] feat;
    } bfn_feat_s;
    typedef struct packed {
        logic [31:0] zsect;
        logic [31:0] zopen;
        logic [31:0] zact;
        logic [31:0] zapp;
        logic [31:0] zgran;
        logic [7:0] model;
    } bfn_zone_s;
    typedef struct packed {
        bfn_phase_e phase;
        logic [31:0] drvFeat;
        logic [7:0] status;
        logic cache;
        logic [31:0] rdData;
    } bfn_main_s;
endpackage

// ### rtl/bfn_feat_offer.sv
// device feature offer word
`timescale 1ns/10ps
module bfn_feat_offer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic legacyMode,
    input wire logic cfgWce,
    input wire logic cfgDiscard,
    input wire logic cfgZoned,
    output logic [31:0] offerFeat
);
    bfn_pkg::bfn_feat_s st_r;
    bfn_pkg::bfn_feat_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.feat = bfn_pkg::FEAT_RST;
        st_nxt.feat[bfn_pkg::FB_FLUSH] = 1'b1;
        st_nxt.feat[bfn_pkg::FB_CACHECFG] = cfgWce;
        st_nxt.feat[bfn_pkg::FB_DISCARD] = cfgDiscard;
        st_nxt.feat[bfn_pkg::FB_ZONED] = cfgZoned & ~legacyMode;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r.feat <= bfn_pkg::FEAT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign offerFeat = st_r.feat;
endmodule // bfn_feat_offer

// ### rtl/bfn_zone_report.sv
// zoned characteristics as reported to the driver
`timescale 1ns/10ps
module bfn_zone_report (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic zonedNeg,
    input wire logic [7:0] cfgModel,
    input wire logic [31:0] cfgZoneSectors,
    input wire logic [31:0] cfgMaxOpen,
    input wire logic [31:0] cfgMaxActive,
    input wire logic [31:0] cfgMaxAppend,
    input wire logic [31:0] cfgSegMax,
    input wire logic [31:0] cfgSizeMax,
    input wire logic [31:0] cfgWriteGran,
    output bfn_pkg::bfn_zone_s zoneRep
);
    bfn_pkg::bfn_zone_s st_r;
    bfn_pkg::bfn_zone_s st_nxt;
    logic seqModel;
    logic [63:0] appLimit;

    always_comb begin
        seqModel = (cfgModel == bfn_pkg::MODEL_HM) || (cfgModel == bfn_pkg::MODEL_HA);
        appLimit = 64'(cfgSegMax) * 64'(cfgSizeMax);
        st_nxt = '0;
        if (zonedNeg) begin
            st_nxt.model = cfgModel;
            if (seqModel) begin
                st_nxt.zsect = cfgZoneSectors;
                st_nxt.zopen = cfgMaxOpen;
                st_nxt.zact = cfgMaxActive;
                st_nxt.zapp = ({32'h0, cfgMaxAppend} > appLimit) ? appLimit[31:0] : cfgMaxAppend;
                st_nxt.zgran = cfgWriteGran;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign zoneRep = st_r;
endmodule // bfn_zone_report

// ### rtl/bfn_feature_bank.sv
// feature negotiation and configuration register bank
`timescale 1ns/10ps
module bfn_feature_bank #(
    parameter logic CACHE_RST_MODE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic legacyMode,
    input wire logic cfgWce,
    input wire logic cfgDiscard,
    input wire logic cfgZoned,
    input wire logic [7:0] cfgModel,
    input wire logic [31:0] cfgZoneSectors,
    input wire logic [31:0] cfgMaxOpen,
    input wire logic [31:0] cfgMaxActive,
    input wire logic [31:0] cfgMaxAppend,
    input wire logic [31:0] cfgSegMax,
    input wire logic [31:0] cfgSizeMax,
    input wire logic [31:0] cfgWriteGran,
    input wire logic cfgUnmapFlag,
    output logic cacheWriteback,
    output logic featuresAccepted,
    output logic driverReady,
    output logic deviceFailed,
    output logic zonedActive
);
    if ($bits(CACHE_RST_MODE) != 1) begin : g_bad_cache_mode
        $error("cache reset mode must be one bit");
    end

    bfn_pkg::bfn_main_s st_r;
    bfn_pkg::bfn_main_s st_nxt;
    logic [31:0] offerFeat;
    bfn_pkg::bfn_zone_s zoneRep;
    logic zonedNeg;
    logic wrFeat;
    logic wrStatus;
    logic wrCache;
    logic [7:0] newStat;
    logic fokRise;
    logic readyRise;
    logic refuseFok;
    logic negWce;
    logic negFlush;
    logic [31:0] rdMux;

    bfn_feat_offer u_offer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .legacyMode(legacyMode),
        .cfgWce(cfgWce),
        .cfgDiscard(cfgDiscard),
        .cfgZoned(cfgZoned),
        .offerFeat(offerFeat)
    );

    bfn_zone_report u_zone (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .zonedNeg(zonedNeg),
        .cfgModel(cfgModel),
        .cfgZoneSectors(cfgZoneSectors),
        .cfgMaxOpen(cfgMaxOpen),
        .cfgMaxActive(cfgMaxActive),
        .cfgMaxAppend(cfgMaxAppend),
        .cfgSegMax(cfgSegMax),
        .cfgSizeMax(cfgSizeMax),
        .cfgWriteGran(cfgWriteGran),
        .zoneRep(zoneRep)
    );

    // negotiated means driver took it and device still offers it
    assign zonedNeg = st_r.drvFeat[bfn_pkg::FB_ZONED] & offerFeat[bfn_pkg::FB_ZONED];
    assign negWce = st_r.drvFeat[bfn_pkg::FB_CACHECFG];
    assign negFlush = st_r.drvFeat[bfn_pkg::FB_FLUSH];

    always_comb begin
        unique case (regAddr)
            bfn_pkg::OFF_FEAT_DEV: rdMux = offerFeat;
            bfn_pkg::OFF_FEAT_DRV: rdMux = st_r.drvFeat;
            bfn_pkg::OFF_STATUS: rdMux = {bfn_pkg::PAD_ZERO, st_r.status};
            bfn_pkg::OFF_CACHE: rdMux = {bfn_pkg::PAD_ZERO, 7'h00, st_r.cache};
            bfn_pkg::OFF_UNMAP: rdMux = {bfn_pkg::PAD_ZERO, 7'h00, cfgUnmapFlag};
            bfn_pkg::OFF_ZSECT: rdMux = zoneRep.zsect;
            bfn_pkg::OFF_ZOPEN: rdMux = zoneRep.zopen;
            bfn_pkg::OFF_ZACT: rdMux = zoneRep.zact;
            bfn_pkg::OFF_ZAPP: rdMux = zoneRep.zapp;
            bfn_pkg::OFF_ZGRAN: rdMux = zoneRep.zgran;
            bfn_pkg::OFF_ZMODEL: rdMux = {bfn_pkg::PAD_ZERO, zoneRep.model};
            default: rdMux = bfn_pkg::WORD_RST;
        endcase
    end

    always_comb begin
        wrFeat = regWr && (regAddr == bfn_pkg::OFF_FEAT_DRV);
        wrStatus = regWr && (regAddr == bfn_pkg::OFF_STATUS);
        wrCache = regWr && (regAddr == bfn_pkg::OFF_CACHE);
        newStat = regWrData[7:0];
        fokRise = newStat[bfn_pkg::ST_FOK] & ~st_r.status[bfn_pkg::ST_FOK];
        readyRise = newStat[bfn_pkg::ST_READY] & ~st_r.status[bfn_pkg::ST_READY];
        // host-managed device without zoned support has its accept refused in modern mode
        refuseFok = (cfgModel == bfn_pkg::MODEL_HM) && !zonedNeg;
        st_nxt = st_r;
        if (regRd) begin
            st_nxt.rdData = rdMux;
        end
        // features freeze once accepted in modern mode
        if (wrFeat && (legacyMode || !st_r.status[bfn_pkg::ST_FOK])) begin
            st_nxt.drvFeat = regWrData & offerFeat;
        end
        if (wrCache) begin
            if (legacyMode) begin
                st_nxt.cache = regWrData[0];
            end else if (negWce && st_r.status[bfn_pkg::ST_FOK]) begin
                st_nxt.cache = regWrData[0];
            end
        end
        if (wrStatus) begin
            if (newStat == bfn_pkg::STATUS_RST) begin
                st_nxt.status = bfn_pkg::STATUS_RST;
                st_nxt.drvFeat = bfn_pkg::FEAT_RST;
                st_nxt.cache = CACHE_RST_MODE;
                st_nxt.phase = bfn_pkg::PH_IDLE;
            end else if (legacyMode) begin
                st_nxt.status = newStat;
                // only a ready without cache-config may move the cache mode
                if (readyRise && !negWce) begin
                    st_nxt.cache = negFlush;
                end
            end else begin
                st_nxt.status = newStat;
                if (fokRise && refuseFok) begin
                    st_nxt.status[bfn_pkg::ST_FOK] = 1'b0;
                end else if (fokRise && negWce && !negFlush) begin
                    st_nxt.cache = bfn_pkg::CACHE_THROUGH;
                end
            end
        end
        if (st_nxt.status[bfn_pkg::ST_FAIL]) begin
            st_nxt.phase = bfn_pkg::PH_FAIL;
        end else if (st_nxt.status[bfn_pkg::ST_READY]) begin
            st_nxt.phase = bfn_pkg::PH_RUN;
        end else if (st_nxt.status[bfn_pkg::ST_FOK]) begin
            st_nxt.phase = bfn_pkg::PH_ACCEPT;
        end else if (st_nxt.status != bfn_pkg::STATUS_RST) begin
            st_nxt.phase = bfn_pkg::PH_NEGOT;
        end else begin
            st_nxt.phase = bfn_pkg::PH_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r.phase <= bfn_pkg::PH_IDLE;
            st_r.drvFeat <= bfn_pkg::FEAT_RST;
            st_r.status <= bfn_pkg::STATUS_RST;
            st_r.cache <= CACHE_RST_MODE;
            st_r.rdData <= bfn_pkg::WORD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign cacheWriteback = st_r.cache;
    assign featuresAccepted = (st_r.phase == bfn_pkg::PH_ACCEPT) || (st_r.phase == bfn_pkg::PH_RUN);
    assign driverReady = st_r.phase == bfn_pkg::PH_RUN;
    assign deviceFailed = st_r.phase == bfn_pkg::PH_FAIL;
    assign zonedActive = zonedNeg;
endmodule // bfn_feature_bank

// ### sim/bfn_bank_chk.sv
// port assertions for the feature negotiation register bank
`timescale 1ns/10ps
module bfn_bank_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic legacyMode,
    input wire logic cfgZoned,
    input wire logic [7:0] cfgModel,
    input wire logic [31:0] cfgSegMax,
    input wire logic [31:0] cfgSizeMax,
    input wire logic cacheWriteback,
    input wire logic featuresAccepted,
    input wire logic zonedActive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [63:0] prod;
    assign prod = 64'(cfgSegMax) * 64'(cfgSizeMax);
    a_flush_offer: assert property (regRd && regAddr == bfn_pkg::OFF_FEAT_DEV && $past(rst_n)
        |=> regRdData[bfn_pkg::FB_FLUSH]) else $error("flush feature not offered");
    a_zoned_offer: assert property (regRd && regAddr == bfn_pkg::OFF_FEAT_DEV && (legacyMode || !cfgZoned)
        |=> !regRdData[bfn_pkg::FB_ZONED]) else $error("zoned feature offered");
    a_pad_zero: assert property (regRd && (regAddr == bfn_pkg::OFF_CACHE || regAddr == bfn_pkg::OFF_UNMAP)
        |=> regRdData[31:1] == 31'h0) else $error("padding not zero");
    a_hm_refuse: assert property (regWr && regAddr == bfn_pkg::OFF_STATUS && regWrData[bfn_pkg::ST_FOK]
        && cfgModel == bfn_pkg::MODEL_HM && !zonedActive |=> !featuresAccepted) else $error("accept not refused");
    a_zone_zero: assert property (regRd && regAddr >= bfn_pkg::OFF_ZSECT && regAddr <= bfn_pkg::OFF_ZMODEL
        && !zonedActive && $past(!zonedActive) |=> regRdData == 32'h0) else $error("zoned field not zero");
    a_model_code: assert property (regRd && regAddr == bfn_pkg::OFF_ZMODEL && zonedActive && $past(zonedActive)
        |=> regRdData == {24'h0, $past(cfgModel, 2)}) else $error("zone model wrong");
    a_append_cap: assert property (regRd && regAddr == bfn_pkg::OFF_ZAPP
        |=> {32'h0, regRdData} <= $past(prod, 2)) else $error("append limit too large");
    a_legacy_cache: assert property (legacyMode && regWr && (regAddr == bfn_pkg::OFF_FEAT_DRV
        || (regAddr == bfn_pkg::OFF_STATUS && regWrData[7:0] != 8'h00 && !regWrData[bfn_pkg::ST_READY]))
        |=> $stable(cacheWriteback)) else $error("legacy cache mode changed");
    c_accept: cover property ($rose(featuresAccepted));
    c_zoned: cover property ($rose(zonedActive));
    c_legacy_change: cover property (legacyMode && $fell(cacheWriteback));
endmodule // bfn_bank_chk

bind bfn_feature_bank bfn_bank_chk u_chk (.clk_sys, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .legacyMode, .cfgZoned, .cfgModel, .cfgSegMax, .cfgSizeMax, .cacheWriteback, .featuresAccepted, .zonedActive);

// ### sim/bfn_guest_drv.sv
// guest driver model: register bus master and feature choice
`timescale 1ns/10ps
module bfn_guest_drv (
    input wire logic clk_sys,
    output logic [7:0] regAddr,
    output logic [31:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [31:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(posedge clk_sys);
        d = regRdData;
    endtask
    // zoned is taken freely since every zone model is handled here
    function automatic logic [31:0] pick(input logic [31:0] offer, input logic [7:0] model, input logic [31:0] rnd);
        logic [31:0] f;
        f = offer & rnd;
        // host-managed zoned device: discard is never taken
        if (offer[bfn_pkg::FB_ZONED] && (rnd[8] || model == bfn_pkg::MODEL_HM)) begin
            f[bfn_pkg::FB_DISCARD] = 1'b0;
        end
        return f;
    endfunction
endmodule // bfn_guest_drv

// ### sim/blk_feature_negotiation_bench.sv
// self-checking bench of the feature negotiation bank
`timescale 1ns/10ps
module blk_feature_negotiation_bench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr, cfgModel = 8'h00;
    logic [31:0] regWrData, regRdData, cfgZoneSectors = 32'h0, cfgMaxOpen = 32'h0, cfgMaxActive = 32'h0;
    logic [31:0] cfgMaxAppend = 32'h0, cfgSegMax = 32'h0, cfgSizeMax = 32'h0, cfgWriteGran = 32'h0;
    logic regWr, regRd, legacyMode = 1'b0, cfgWce = 1'b0, cfgDiscard = 1'b0, cfgZoned = 1'b0, cfgUnmapFlag = 1'b0;
    logic cacheWriteback, featuresAccepted, driverReady, deviceFailed, zonedActive;
    int nErrors = 0, numChecks = 0;
    always #2.5 clk_sys = ~clk_sys;
    bfn_feature_bank u_dut (.clk_sys, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .legacyMode,
        .cfgWce, .cfgDiscard, .cfgZoned, .cfgModel, .cfgZoneSectors, .cfgMaxOpen, .cfgMaxActive, .cfgMaxAppend,
        .cfgSegMax, .cfgSizeMax, .cfgWriteGran, .cfgUnmapFlag, .cacheWriteback, .featuresAccepted, .driverReady,
        .deviceFailed, .zonedActive);
    bfn_guest_drv u_drv (.clk_sys, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [31:0] zexp(input logic [7:0] a, input logic zn);
        logic [63:0] cap;
        cap = cfgSegMax * cfgSizeMax;
        if (!zn) return 32'h0;
        if (a == bfn_pkg::OFF_ZMODEL) return {24'h0, cfgModel};
        if (cfgModel == bfn_pkg::MODEL_NONE) return 32'h0;
        case (a)
            bfn_pkg::OFF_ZSECT: return cfgZoneSectors;
            bfn_pkg::OFF_ZOPEN: return cfgMaxOpen;
            bfn_pkg::OFF_ZACT: return cfgMaxActive;
            bfn_pkg::OFF_ZAPP: return (cfgMaxAppend > cap) ? cap[31:0] : cfgMaxAppend;
            default: return cfgWriteGran;
        endcase
    endfunction
    initial begin
        repeat (20000) @(posedge clk_sys);
        nErrors++;
        print_verdict;
    end
    initial begin
        logic [31:0] offer, want, got;
        logic [7:0] m;
        logic z, cc, fl, zn, ok;
        got = $urandom(91);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        u_drv.rd(bfn_pkg::OFF_FEAT_DRV, got);
        check(got, bfn_pkg::FEAT_RST);
        check({27'h0, cacheWriteback, featuresAccepted, driverReady, deviceFailed, zonedActive}, 32'h10);
        for (int i = 0; i < 40; i++) begin
            u_drv.wr(bfn_pkg::OFF_STATUS, 32'h0);
            z = (i == 0) || ($urandom % 2 == 1);
            m = (i == 0) ? bfn_pkg::MODEL_HM : (z ? 8'($urandom % 3) : bfn_pkg::MODEL_NONE);
            legacyMode <= (i == 1) || (i > 2 && $urandom % 4 == 0);
            cfgWce <= (i < 3) || ($urandom % 2 == 1);
            cfgDiscard <= $urandom % 2 == 1;
            cfgUnmapFlag <= $urandom % 2 == 1;
            cfgZoned <= z;
            cfgModel <= m;
            cfgZoneSectors <= $urandom;
            cfgMaxOpen <= $urandom % 8;
            cfgMaxActive <= $urandom % 8;
            cfgMaxAppend <= $urandom % 65536;
            cfgSegMax <= $urandom % 16;
            cfgSizeMax <= $urandom % 4096;
            cfgWriteGran <= (m == bfn_pkg::MODEL_NONE) ? 32'h0 : $urandom;
            u_drv.rd(bfn_pkg::OFF_FEAT_DEV, offer);
            check(offer, {28'h0, z && !legacyMode, cfgDiscard, cfgWce, 1'b1});
            want = u_drv.pick(offer, m, (i == 0) ? 32'h3 : (i == 1) ? 32'h0 : (i == 2) ? 32'h2 : $urandom);
            u_drv.wr(bfn_pkg::OFF_FEAT_DRV, want);
            u_drv.rd(bfn_pkg::OFF_FEAT_DRV, got);
            check(got, want);
            cc = want[bfn_pkg::FB_CACHECFG];
            fl = want[bfn_pkg::FB_FLUSH];
            zn = want[bfn_pkg::FB_ZONED];
            ok = !(m == bfn_pkg::MODEL_HM && !zn);
            if (!legacyMode && zn && m == bfn_pkg::MODEL_HM && $urandom % 4 == 0) begin
                // a driver without host-managed support gives up instead of accepting
                u_drv.rd(bfn_pkg::OFF_ZMODEL, got);
                check(got, {24'h0, bfn_pkg::MODEL_HM});
                u_drv.wr(bfn_pkg::OFF_STATUS, 32'h83);
                u_drv.rd(bfn_pkg::OFF_STATUS, got);
                check(got, 32'h83);
                check({30'h0, featuresAccepted, deviceFailed}, 32'h1);
                continue;
            end
            if (legacyMode) begin
                u_drv.wr(bfn_pkg::OFF_CACHE, 32'h0);
                u_drv.rd(bfn_pkg::OFF_CACHE, got);
                check(got, 32'h0);
                u_drv.wr(bfn_pkg::OFF_CACHE, 32'h1);
            end
            u_drv.wr(bfn_pkg::OFF_STATUS, legacyMode ? 32'h3 : 32'hb);
            u_drv.rd(bfn_pkg::OFF_STATUS, got);
            check(got, (legacyMode || !ok) ? 32'h3 : 32'hb);
            if (legacyMode || ok) begin
                u_drv.rd(bfn_pkg::OFF_CACHE, got); // read after accepted bit, or after driver bit in legacy mode
                check(got, {31'h0, !(cc && !fl && !legacyMode)});
            end else begin
                check({31'h0, featuresAccepted}, 32'h0);
            end
            for (logic [7:0] a = bfn_pkg::OFF_ZSECT; a <= bfn_pkg::OFF_ZMODEL; a += 8'h4) begin
                u_drv.rd(a, got);
                check(got, zexp(a, zn));
            end
            check({30'h0, zonedActive, cacheWriteback}, {30'h0, zn, !(cc && !fl && ok && !legacyMode)});
            u_drv.rd(bfn_pkg::OFF_UNMAP, got);
            check(got, {31'h0, cfgUnmapFlag});
            u_drv.rd(8'h3c, got);
            check(got, 32'h0);
            if (legacyMode || ok) begin
                u_drv.wr(bfn_pkg::OFF_STATUS, legacyMode ? 32'h7 : 32'hf);
                u_drv.rd(bfn_pkg::OFF_CACHE, got);
                check(got, {31'h0, legacyMode ? (cc || fl) : !(cc && !fl)});
                check({30'h0, driverReady, deviceFailed}, 32'h2);
                // cache writes land in legacy mode, or once cache-config is accepted
                u_drv.wr(bfn_pkg::OFF_CACHE, 32'h0);
                u_drv.rd(bfn_pkg::OFF_CACHE, got);
                check(got, {31'h0, !(legacyMode || cc)});
            end
        end
        print_verdict;
    end
endmodule // blk_feature_negotiation_bench
